// >>> rtl/otc_consts.svh
// Purpose: offsets, field positions, reset values and figures of the oscillator control
// Assumes: included by its bare name after the package
// Notes: register port uses a two-bit register select
`ifndef OTC_CONSTS_SVH
`define OTC_CONSTS_SVH

// register selects
`define OTC_ADDR_TRIM 2'h0
`define OTC_ADDR_OSC_MODE 2'h1
`define OTC_ADDR_PIN_MODE 2'h2
`define OTC_ADDR_CPU_CLK 2'h3

// trim register
`define OTC_TRIM_RST 8'h10
`define OTC_TRIM_MASK 8'h1F
`define OTC_TRIM_ZERO 6'h10
`define OTC_TRIM_MSB 4
`define OTC_TRIM_LSB 0

// internal oscillation mode register fields
`define OTC_MODE_HS_STOP 0
`define OTC_MODE_LS_STOP 1
`define OTC_MODE_HS_RUN 6
`define OTC_MODE_LS_RUN 7
`define OTC_MODE_RST 2'h0

// clock pin mode register fields
`define OTC_PIN_EXT_CLK 7
`define OTC_PIN_MAIN_XTAL 6
`define OTC_PIN_SUB_SEL 4
`define OTC_PIN_RST 3'h0

// cpu clock register fields
`define OTC_CPU_SEL_MSB 1
`define OTC_CPU_SEL_LSB 0
`define OTC_CPU_SEL_HS_INT 2'h0
`define OTC_CPU_SEL_HS_SYS 2'h1
`define OTC_CPU_SEL_SUB 2'h2

// nominal frequencies
`define OTC_HS_OSC_KHZ 8000
`define OTC_LS_OSC_KHZ 240
`define OTC_MAIN_XTAL_MIN_KHZ 2000
`define OTC_MAIN_XTAL_MAX_KHZ 10000
`define OTC_SUB_XTAL_HZ 32768

// prescaler taps
`define OTC_PRS_TAPS 5

`endif

// >>> rtl/otc_pkg.sv
// Purpose: types shared by the oscillator control
// Assumes: nothing
// Notes: one-hot cpu clock source codes
package otc_pkg;

	typedef enum logic [2:0] {
		OTC_SRC_HS_INT = 3'b001,
		OTC_SRC_HS_SYS = 3'b010,
		OTC_SRC_SUB = 3'b100
	} otc_cpu_src_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] sel;
		logic [7:0] wdata;
	} otc_reg_req_s;

	typedef struct packed {
		logic wdt;
		logic tmr;
		logic lcd;
	} otc_ls_route_s;

endpackage

// >>> rtl/otc_sync2.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: levels only, no pulses
// Notes: first stage read only by second stage
`timescale 1ns/10ps
module otc_sync2 #(
	parameter int WIDTH = 2
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			meta_reg <= '0;
			o_sync <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end

endmodule // otc_sync2

// >>> rtl/otc_prescaler.sv
// Purpose: divides the main system clock into a set of tick strobes
// Assumes: i_run high while the main system clock feeds the cpu
// Notes: tick k pulses once every 2**(k+1) running cycles
`timescale 1ns/10ps
module otc_prescaler #(
	parameter int TAPS = 5
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_run,
	output logic [TAPS-1:0] o_tick
);

	logic [TAPS-1:0] cnt_reg;
	logic [TAPS-1:0] cnt_next;
	logic [TAPS-1:0] tick_next;

	assign cnt_next = i_run ? cnt_reg + {{(TAPS-1){1'b0}}, 1'b1} : '0;

	// per-tap strobe when its low bits are all ones
	for (genvar k = 0; k < TAPS; k++) begin : g_tap
		assign tick_next[k] = i_run && (&cnt_reg[k:0]);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cnt_reg <= '0;
			o_tick <= '0;
		end else begin
			cnt_reg <= cnt_next;
			o_tick <= tick_next;
		end
	end

endmodule // otc_prescaler

// >>> rtl/otc_osc_ctrl.sv
// Purpose: trim register and start/stop control of the on-chip oscillators
// Assumes: option settings arrive as static pin levels
// Notes: register port takes a whole byte per write
//
// Behaviour
// - Any system reset loads the trim register with 0x10, zero correction.
// - Trim register is eight bits: bits 7..5 zero, trim code in 4..0.
// - Trim code is an offset around 10000b; lower slows, higher speeds up.
// - Frequency follows the trim code monotonically in both directions.
// - High-speed internal oscillator starts by itself after reset, nominal 8 MHz.
// - A mode register bit lets software start or stop the high-speed oscillator.
// - Low-speed clock feeds only watchdog, timer and display; never the cpu.
// - Option setting decides whether the mode register may stop the low-speed oscillator.
// - Low-speed oscillator starts after reset; watchdog runs on it if enabled.
// - Prescaler divides the main clock whenever that clock feeds the cpu.
// - High-speed system clock comes from main crystal or external clock pin.
// - Subsystem clock source is a 32.768 kHz crystal oscillator.
`timescale 1ns/10ps
`include "otc_consts.svh"
module otc_osc_ctrl
	import otc_pkg::*;
#(
	parameter int PRS_TAPS = `OTC_PRS_TAPS
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire otc_reg_req_s i_req,
	input wire logic i_opt_ls_stoppable,
	input wire logic i_opt_wdt_en,
	input wire logic i_tmr_ls_sel,
	input wire logic i_lcd_ls_sel,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic [4:0] o_hs_trim,
	output logic signed [5:0] o_hs_trim_offset,
	output logic o_hs_osc_en,
	output logic o_ls_osc_en,
	output logic o_main_xtal_en,
	output logic o_ext_clk_sel,
	output logic o_sub_pin_sel,
	output logic o_sub_xtal_en,
	output otc_cpu_src_e o_cpu_src,
	output otc_ls_route_s o_ls_route,
	output logic [PRS_TAPS-1:0] o_prs_tick
);

	////////////////////////////////////////////////////////////////////////////////
	// option pins

	logic [1:0] opt_sync;
	logic ls_stoppable;
	logic wdt_enabled;

	otc_sync2 #(
		.WIDTH(2)
	) u_opt_sync (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_async({i_opt_ls_stoppable, i_opt_wdt_en}),
		.o_sync(opt_sync)
	);

	assign ls_stoppable = opt_sync[1];
	assign wdt_enabled = opt_sync[0];

	////////////////////////////////////////////////////////////////////////////////
	// register state

	logic [4:0] trim_reg;
	logic [4:0] trim_next;
	logic [1:0] mode_reg;
	logic [1:0] mode_next;
	logic [2:0] pin_reg;
	logic [2:0] pin_next;
	otc_cpu_src_e cpu_src_reg;
	otc_cpu_src_e cpu_src_next;
	logic hs_run_reg;
	logic hs_run_next;
	logic ls_run_reg;
	logic ls_run_next;

	////////////////////////////////////////////////////////////////////////////////
	// write decode

	logic wr_trim;
	logic wr_mode;
	logic wr_pin;
	logic wr_cpu;
	logic [1:0] cpu_sel_wr;

	assign wr_trim = i_req.wr && (i_req.sel == `OTC_ADDR_TRIM);
	assign wr_mode = i_req.wr && (i_req.sel == `OTC_ADDR_OSC_MODE);
	assign wr_pin = i_req.wr && (i_req.sel == `OTC_ADDR_PIN_MODE);
	assign wr_cpu = i_req.wr && (i_req.sel == `OTC_ADDR_CPU_CLK);
	assign cpu_sel_wr = i_req.wdata[`OTC_CPU_SEL_MSB:`OTC_CPU_SEL_LSB];

	// whole-byte write, upper three bits dropped
	assign trim_next = wr_trim ? i_req.wdata[`OTC_TRIM_MSB:`OTC_TRIM_LSB] : trim_reg;

	assign mode_next = wr_mode ?
		{i_req.wdata[`OTC_MODE_LS_STOP], i_req.wdata[`OTC_MODE_HS_STOP]} : mode_reg;

	// pin mode: external clock, main crystal, subsystem pin select
	assign pin_next = wr_pin ? {i_req.wdata[`OTC_PIN_EXT_CLK], i_req.wdata[`OTC_PIN_MAIN_XTAL],
		i_req.wdata[`OTC_PIN_SUB_SEL]} : pin_reg;

	////////////////////////////////////////////////////////////////////////////////
	// cpu clock source, low-speed clock is never a choice

	logic hs_sys_ready;
	logic sub_ready;

	assign hs_sys_ready = pin_reg[2] || pin_reg[1];
	assign sub_ready = pin_reg[0];

	always_comb begin
		cpu_src_next = cpu_src_reg;
		if (wr_cpu) begin
			unique case (cpu_sel_wr)
				`OTC_CPU_SEL_HS_INT: begin
					if (hs_run_reg) begin
						cpu_src_next = OTC_SRC_HS_INT;
					end
				end
				`OTC_CPU_SEL_HS_SYS: begin
					if (hs_sys_ready) begin
						cpu_src_next = OTC_SRC_HS_SYS;
					end
				end
				`OTC_CPU_SEL_SUB: begin
					if (sub_ready) begin
						cpu_src_next = OTC_SRC_SUB;
					end
				end
				default: begin
					cpu_src_next = cpu_src_reg;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// oscillator run control

	logic hs_stop_req;
	logic ls_stop_req;

	// high-speed stop refused while it clocks the cpu
	assign hs_stop_req = mode_next[0] && (cpu_src_next != OTC_SRC_HS_INT);
	assign hs_run_next = !hs_stop_req;

	// low-speed stop only honoured when the option allows it
	assign ls_stop_req = mode_next[1] && ls_stoppable;
	assign ls_run_next = !ls_stop_req;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			trim_reg <= 5'(`OTC_TRIM_RST);
			mode_reg <= `OTC_MODE_RST;
			pin_reg <= `OTC_PIN_RST;
			cpu_src_reg <= OTC_SRC_HS_INT;
			hs_run_reg <= 1'b1;
			ls_run_reg <= 1'b1;
		end else begin
			trim_reg <= trim_next;
			mode_reg <= mode_next;
			pin_reg <= pin_next;
			cpu_src_reg <= cpu_src_next;
			hs_run_reg <= hs_run_next;
			ls_run_reg <= ls_run_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path

	logic [7:0] rd_trim;
	logic [7:0] rd_mode;
	logic [7:0] rd_pin;
	logic [7:0] rd_cpu;
	logic [1:0] cpu_code;
	logic [7:0] rd_mux;

	assign rd_trim = {3'h0, trim_reg};
	assign rd_mode = {ls_run_reg, hs_run_reg, 4'h0, mode_reg};
	assign rd_pin = {pin_reg[2], pin_reg[1], 1'b0, pin_reg[0], 4'h0};
	assign cpu_code = (cpu_src_reg == OTC_SRC_HS_SYS) ? `OTC_CPU_SEL_HS_SYS :
		(cpu_src_reg == OTC_SRC_SUB) ? `OTC_CPU_SEL_SUB : `OTC_CPU_SEL_HS_INT;
	assign rd_cpu = {6'h00, cpu_code};

	assign rd_mux = (i_req.sel == `OTC_ADDR_TRIM) ? rd_trim :
		(i_req.sel == `OTC_ADDR_OSC_MODE) ? rd_mode :
		(i_req.sel == `OTC_ADDR_PIN_MODE) ? rd_pin : rd_cpu;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_data <= i_req.rd ? rd_mux : 8'h00;
			o_rd_valid <= i_req.rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog trim and clock routing outputs

	logic signed [5:0] trim_offset;
	otc_ls_route_s route_next;

	// code minus 10000b, monotonic in the code
	assign trim_offset = $signed({1'b0, trim_reg}) - $signed(`OTC_TRIM_ZERO);

	// low-speed clock only to watchdog, timer and display
	assign route_next.wdt = ls_run_reg && wdt_enabled;
	assign route_next.tmr = ls_run_reg && i_tmr_ls_sel;
	assign route_next.lcd = ls_run_reg && i_lcd_ls_sel;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_hs_trim <= 5'(`OTC_TRIM_RST);
			o_hs_trim_offset <= 6'h00;
			o_hs_osc_en <= 1'b1;
			o_ls_osc_en <= 1'b1;
			o_main_xtal_en <= 1'b0;
			o_ext_clk_sel <= 1'b0;
			o_sub_pin_sel <= 1'b0;
			o_sub_xtal_en <= 1'b0;
			o_cpu_src <= OTC_SRC_HS_INT;
			o_ls_route <= '0;
		end else begin
			o_hs_trim <= trim_reg;
			o_hs_trim_offset <= trim_offset;
			o_hs_osc_en <= hs_run_reg;
			o_ls_osc_en <= ls_run_reg;
			o_main_xtal_en <= pin_reg[1] && !pin_reg[2];
			o_ext_clk_sel <= pin_reg[2];
			o_sub_pin_sel <= pin_reg[0];
			o_sub_xtal_en <= pin_reg[0];
			o_cpu_src <= cpu_src_reg;
			o_ls_route <= route_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// prescaler on the main system clock

	logic main_on_cpu;

	assign main_on_cpu = (cpu_src_reg == OTC_SRC_HS_INT) || (cpu_src_reg == OTC_SRC_HS_SYS);

	otc_prescaler #(
		.TAPS(PRS_TAPS)
	) u_prescaler (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_run(main_on_cpu),
		.o_tick(o_prs_tick)
	);

endmodule // otc_osc_ctrl

// >>> tb/otc_osc_ctrl_asserts.sv
// Purpose: port assertions for the oscillator control
// Assumes: bound into otc_osc_ctrl
// Notes: one clock domain
`timescale 1ns/10ps
module otc_osc_ctrl_asserts
	import otc_pkg::*;
#(
	parameter int PRS_TAPS = 5
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire otc_reg_req_s i_req,
	input wire logic i_opt_ls_stoppable,
	input wire logic [7:0] o_rd_data,
	input wire logic o_rd_valid,
	input wire logic [4:0] o_hs_trim,
	input wire logic signed [5:0] o_hs_trim_offset,
	input wire logic o_hs_osc_en,
	input wire logic o_ls_osc_en,
	input wire logic o_main_xtal_en,
	input wire logic o_ext_clk_sel,
	input wire otc_cpu_src_e o_cpu_src,
	input wire logic [PRS_TAPS-1:0] o_prs_tick
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	sequence trim_wr;
		i_req.wr && i_req.sel == 2'h0;
	endsequence
	sequence on_sub3;
		(o_cpu_src == OTC_SRC_SUB) [*3];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	trim_rst_a: assert property (disable iff (1'b0) i_sys_rst |=> o_hs_trim == 5'h10
		&& o_hs_trim_offset == 6'sh00 && o_hs_osc_en && o_cpu_src == OTC_SRC_HS_INT)
		else $error("trim or start state wrong after reset");
	trim_wr_a: assert property (trim_wr |=> ##1 o_hs_trim == $past(i_req.wdata[4:0], 2))
		else $error("trim code does not follow write");
	trim_offset_a: assert property (o_hs_trim_offset == $signed({1'b0, o_hs_trim}) - 6'sh10)
		else $error("trim offset does not match code");
	trim_rd_a: assert property (i_req.rd && i_req.sel == 2'h0 |=> o_rd_valid
		&& o_rd_data == {3'h0, o_hs_trim})
		else $error("trim read wrong");
	idle_rd_a: assert property (!i_req.rd |=> !o_rd_valid && o_rd_data == 8'h00)
		else $error("read data without read");
	hs_keep_a: assert property (o_cpu_src == OTC_SRC_HS_INT |-> o_hs_osc_en)
		else $error("high-speed oscillator stopped under cpu");
	ls_keep_a: assert property (!i_opt_ls_stoppable [*6] |-> o_ls_osc_en)
		else $error("low-speed oscillator stopped while not stoppable");
	cpu_src_a: assert property (o_cpu_src inside {OTC_SRC_HS_INT, OTC_SRC_HS_SYS, OTC_SRC_SUB})
		else $error("illegal cpu clock source");
	xtal_ext_a: assert property (o_main_xtal_en |-> !o_ext_clk_sel)
		else $error("crystal and external clock both on");
	prs_sub_a: assert property (on_sub3 |-> o_prs_tick == '0)
		else $error("prescaler ticks on subsystem clock");
	prs_run_a: assert property (o_prs_tick[0] && o_cpu_src != OTC_SRC_SUB |=> !o_prs_tick[0])
		else $error("prescaler tick too long");
endmodule // otc_osc_ctrl_asserts

// >>> tb/tb_otc_osc_ctrl.sv
// Purpose: self-checking bench of the oscillator control
// Assumes: inputs driven at falling edges
// Notes: second reset flips the option levels
`timescale 1ns/10ps
`include "otc_consts.svh"
module tb_otc_osc_ctrl
	import otc_pkg::*;
;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	otc_reg_req_s i_req = '0;
	logic i_opt_ls_stoppable = 1'b0;
	logic i_opt_wdt_en = 1'b1;
	logic i_tmr_ls_sel = 1'b0;
	logic i_lcd_ls_sel = 1'b0;
	logic [7:0] o_rd_data, rv;
	logic o_rd_valid, o_hs_osc_en, o_ls_osc_en, o_main_xtal_en, o_ext_clk_sel;
	logic o_sub_pin_sel, o_sub_xtal_en;
	logic [4:0] o_hs_trim, o_prs_tick;
	logic signed [5:0] o_hs_trim_offset;
	otc_cpu_src_e o_cpu_src;
	otc_ls_route_s o_ls_route;
	int fail_count = 0;
	int n_compared = 0;
	int k;
	always #20 i_clk_sys = ~i_clk_sys;
	otc_osc_ctrl dut (.i_clk_sys, .i_sys_rst, .i_req, .i_opt_ls_stoppable, .i_opt_wdt_en,
		.i_tmr_ls_sel, .i_lcd_ls_sel, .o_rd_data, .o_rd_valid, .o_hs_trim, .o_hs_trim_offset,
		.o_hs_osc_en, .o_ls_osc_en, .o_main_xtal_en, .o_ext_clk_sel, .o_sub_pin_sel,
		.o_sub_xtal_en, .o_cpu_src, .o_ls_route, .o_prs_tick);
	////////////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		i_req.wr = 1'b1;
		i_req.sel = a;
		i_req.wdata = d;
		cyc(1);
		i_req.wr = 1'b0;
		cyc(1);
	endtask
	task rd(input logic [1:0] a, output logic [7:0] d);
		i_req.rd = 1'b1;
		i_req.sel = a;
		cyc(1);
		i_req.rd = 1'b0;
		chk("rd_valid", {7'h0, o_rd_valid}, 8'h01);
		d = o_rd_data;
		cyc(1);
	endtask
	task rst();
		i_sys_rst = 1'b1;
		cyc(6);
		i_sys_rst = 1'b0;
		cyc(3);
	endtask
	task ticks(output int c);
		c = 0;
		repeat (8) begin
			cyc(1);
			c += int'(o_prs_tick[0] === 1'b1);
		end
	endtask
	task cpu(input logic [7:0] v, input otc_cpu_src_e e);
		wr(`OTC_ADDR_CPU_CLK, v);
		cyc(2);
		chk("cpu_src", {5'h0, o_cpu_src}, {5'h0, e});
	endtask
	task stop_test();
		$display("fail_count %0d n_compared %0d", fail_count, n_compared);
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(3000);
		fail_count++;
		stop_test();
	end
	initial begin
		rst();
		chk("osc_en", {6'h0, o_hs_osc_en, o_ls_osc_en}, 8'h03);
		chk("wdt", {7'h0, o_ls_route.wdt}, 8'h01);
		rd(`OTC_ADDR_TRIM, rv);
		chk("trim", rv, `OTC_TRIM_RST);
		cpu(8'h01, OTC_SRC_HS_INT);
		cpu(8'h02, OTC_SRC_HS_INT);
		for (k = 0; k < 32; k++) begin
			wr(`OTC_ADDR_TRIM, 8'hE0 | 8'(k));
			rd(`OTC_ADDR_TRIM, rv);
			chk("trim", rv, 8'(k));
			chk("code", {3'h0, o_hs_trim}, 8'(k));
			chk("offset", 8'(o_hs_trim_offset), 8'(k - 16));
		end
		i_tmr_ls_sel = 1'b1;
		i_lcd_ls_sel = 1'b1;
		cyc(3);
		chk("route", {5'h0, o_ls_route}, 8'h07);
		wr(`OTC_ADDR_OSC_MODE, 8'h03);
		cyc(2);
		chk("osc_en", {6'h0, o_hs_osc_en, o_ls_osc_en}, 8'h03);
		rd(`OTC_ADDR_OSC_MODE, rv);
		chk("mode", rv, 8'hC3);
		wr(`OTC_ADDR_PIN_MODE, 8'h40);
		cyc(2);
		chk("xtal", {6'h0, o_main_xtal_en, o_ext_clk_sel}, 8'h02);
		wr(`OTC_ADDR_PIN_MODE, 8'hC0);
		cyc(2);
		chk("ext", {6'h0, o_main_xtal_en, o_ext_clk_sel}, 8'h01);
		cpu(8'h01, OTC_SRC_HS_SYS);
		chk("hs_en", {7'h0, o_hs_osc_en}, 8'h00);
		ticks(k);
		chk("ticks", 8'(k), 8'h04);
		wr(`OTC_ADDR_PIN_MODE, 8'hD0);
		cpu(8'h02, OTC_SRC_SUB);
		chk("sub_pin", {7'h0, o_sub_pin_sel}, 8'h01);
		chk("sub_xtal", {7'h0, o_sub_xtal_en}, 8'h01);
		rd(`OTC_ADDR_PIN_MODE, rv);
		chk("pin", rv, 8'hD0);
		rd(`OTC_ADDR_CPU_CLK, rv);
		chk("cpu_code", rv, 8'h02);
		ticks(k);
		chk("ticks", 8'(k), 8'h00);
		cpu(8'h03, OTC_SRC_SUB);
		cpu(8'h00, OTC_SRC_SUB);
		wr(`OTC_ADDR_OSC_MODE, 8'h02);
		cyc(2);
		chk("osc_en", {6'h0, o_hs_osc_en, o_ls_osc_en}, 8'h03);
		cpu(8'h00, OTC_SRC_HS_INT);
		i_opt_ls_stoppable = 1'b1;
		i_opt_wdt_en = 1'b0;
		rst();
		chk("code", {3'h0, o_hs_trim}, `OTC_TRIM_RST);
		chk("wdt", {7'h0, o_ls_route.wdt}, 8'h00);
		wr(`OTC_ADDR_OSC_MODE, 8'h02);
		cyc(2);
		chk("osc_en", {6'h0, o_hs_osc_en, o_ls_osc_en}, 8'h02);
		wr(`OTC_ADDR_TRIM, 8'h15);
		rd(`OTC_ADDR_TRIM, rv);
		chk("retrim", rv, 8'h15);
		stop_test();
	end
endmodule // tb_otc_osc_ctrl
bind otc_osc_ctrl otc_osc_ctrl_asserts #(.PRS_TAPS(PRS_TAPS)) u_chk (.i_clk_sys, .i_sys_rst,
	.i_req, .i_opt_ls_stoppable, .o_rd_data, .o_rd_valid, .o_hs_trim, .o_hs_trim_offset,
	.o_hs_osc_en, .o_ls_osc_en, .o_main_xtal_en, .o_ext_clk_sel, .o_cpu_src, .o_prs_tick);
